/* logic/fpm_regs.vh */
// register map, field positions, reset values and timing counts of the
// frequency / period / pulse measurement channel
// assumes a 32-bit apb slave clocked by pclk at 125 mhz
`ifndef FPM_REGS_VH
`define FPM_REGS_VH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define FPM_CTRL_OFS      12'h000
`define FPM_COMPARE_OFS   12'h004
`define FPM_STATUS_OFS    12'h008
`define FPM_LOW_PAIR_OFS  12'h00c
`define FPM_HIGH_PAIR_OFS 12'h010
`define FPM_RESULT_OFS    12'h014
`define FPM_REF_DIV_OFS   12'h018

// ****************************************************************
// control fields
// ****************************************************************
`define FPM_CTRL_MODE_LSB 0
`define FPM_CTRL_MODE_MSB 4
`define FPM_CTRL_REFSEL   7
`define FPM_CTRL_RESET    32'h0000_0000

// ****************************************************************
// mode encodings
// ****************************************************************
`define FPM_MODE_PULSE_LOW 5'h06
`define FPM_MODE_FREQ      5'h10
`define FPM_MODE_PERIOD    5'h11
`define FPM_MODE_FREQ_GATE 5'h12

// ****************************************************************
// reset values and timing
// ****************************************************************
`define FPM_COMPARE_RESET 32'h0000_0001
`define FPM_REF_DIV_RESET 32'h0000_007d
`define FPM_CLK_HZ        125000000
`define FPM_BASE_HZ       50000
`define FPM_BASE_DIV      (`FPM_CLK_HZ / `FPM_BASE_HZ)

`endif

/* logic/fpm_tick.v */
// enable pulse divider: one pclk-wide tick every div cycles
// assumes div of zero or one gives a tick every cycle
`timescale 1ns/1ns
`default_nettype none

module fpm_tick #(
  parameter WIDTH = 32
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire [WIDTH-1:0] div,
  output reg              tick
);

  reg [WIDTH-1:0] count;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {WIDTH{1'b0}};
      tick  <= 1'b0;
    end else if (count + {{(WIDTH-1){1'b0}}, 1'b1} >= div) begin
      count <= {WIDTH{1'b0}};
      tick  <= 1'b1;
    end else begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      tick  <= 1'b0;
    end
  end

endmodule // fpm_tick

`default_nettype wire

/* logic/fpm_channel.v */
// measurement channel: frequency, period, gated frequency, pulse-low
// assumes field inputs synchronous to pclk, apb master per amba spec
//
// Overview of operation
// - compare holds n, 1 to 2^32-1
// - period measurement starts on start rising edge
// - period: high pair counts reference pulses
// - period: low pair counts clock rising edges
// - stop at compare match or stop high
// - frequency: high pair clocks, low pair reference
// - control bit 7 selects reference frequency
// - gated mode: out1 is inverted gate
// - measurement modes occupy the whole channel
// - pulse-low: falling edge starts, rising stops
// - pulse-low counts with fixed 50khz base
// - direction low counts up, high down
// - clear input high clears the counter
// - result latched on rising edge, held
// - pulse-low leaves both outputs unchanged
// - frequency: low pair starts at clock edge
`timescale 1ns/1ns
`default_nettype none
`include "fpm_regs.vh"

module fpm_channel (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        clk_in,
  input  wire        counter_clear_input,
  input  wire        start_in,
  input  wire        stop_in,
  input  wire        dir_in,
  output reg         out0,
  output reg         out1
);

  // ****************************************************************
  // state codes
  // ****************************************************************
  localparam ST_IDLE = 2'd0;
  localparam ST_ARM  = 2'd1;
  localparam ST_RUN  = 2'd2;
  localparam ST_DONE = 2'd3;

  // ****************************************************************
  // registers and decoded inputs
  // ****************************************************************
  reg [31:0] ctrl;
  reg [31:0] compare;
  reg [31:0] ref_div;
  reg [31:0] low_pair;
  reg [31:0] high_pair;
  reg [31:0] pulse_count;
  reg [31:0] result_input_area;
  reg [1:0]  state;
  reg        clk_d;
  reg        start_d;
  reg        pulse_run;
  reg        result_new;
  reg        done_flag;
  reg [31:0] next_low;
  reg [31:0] next_high;
  reg [31:0] next_prdata;

  // ****************************************************************
  // mode decode and edge strobes
  // ****************************************************************
  wire [4:0] mode = ctrl[`FPM_CTRL_MODE_MSB:`FPM_CTRL_MODE_LSB];
  wire       reference_select_byte_bit = ctrl[`FPM_CTRL_REFSEL];
  wire       clk_rise  = clk_in & ~clk_d;
  wire       clk_fall  = ~clk_in & clk_d;
  wire       start_rise = start_in & ~start_d;
  wire       is_freq   = (mode == `FPM_MODE_FREQ) ||
                         (mode == `FPM_MODE_FREQ_GATE);
  wire       is_period = (mode == `FPM_MODE_PERIOD);
  wire       is_meas   = is_freq | is_period;
  wire       is_pulse  = (mode == `FPM_MODE_PULSE_LOW);
  wire       ref_tick;
  wire       base_tick;
  wire       wr_en = psel & penable & pwrite;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  function addr_hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      addr_hit = (a == ofs);
    end
  endfunction

  wire known = addr_hit(paddr, `FPM_CTRL_OFS) ||
               addr_hit(paddr, `FPM_COMPARE_OFS) ||
               addr_hit(paddr, `FPM_STATUS_OFS) ||
               addr_hit(paddr, `FPM_LOW_PAIR_OFS) ||
               addr_hit(paddr, `FPM_HIGH_PAIR_OFS) ||
               addr_hit(paddr, `FPM_RESULT_OFS) ||
               addr_hit(paddr, `FPM_REF_DIV_OFS);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~known;

  // ****************************************************************
  // register write
  // ****************************************************************
  // a zero compare would end a measurement at once, so it is refused
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= `FPM_CTRL_RESET;
      compare <= `FPM_COMPARE_RESET;
      ref_div <= `FPM_REF_DIV_RESET;
    end else if (wr_en) begin
      if (addr_hit(paddr, `FPM_CTRL_OFS))
        ctrl <= pwdata;
      if (addr_hit(paddr, `FPM_COMPARE_OFS) && pwdata != 32'h0000_0000)
        compare <= pwdata;
      if (addr_hit(paddr, `FPM_REF_DIV_OFS))
        ref_div <= pwdata;
    end
  end

  // ****************************************************************
  // register read
  // ****************************************************************
  always @* begin
    next_prdata = 32'h0000_0000;
    if (psel) begin
      if (addr_hit(paddr, `FPM_CTRL_OFS))
        next_prdata = ctrl;
      if (addr_hit(paddr, `FPM_COMPARE_OFS))
        next_prdata = compare;
      if (addr_hit(paddr, `FPM_STATUS_OFS))
        next_prdata = {28'h0000000, result_new, done_flag, state};
      if (addr_hit(paddr, `FPM_LOW_PAIR_OFS))
        next_prdata = low_pair;
      if (addr_hit(paddr, `FPM_HIGH_PAIR_OFS))
        next_prdata = high_pair;
      if (addr_hit(paddr, `FPM_RESULT_OFS))
        next_prdata = result_input_area;
      if (addr_hit(paddr, `FPM_REF_DIV_OFS))
        next_prdata = ref_div;
    end
  end

  // the read word is captured in the setup cycle, so it stands as a
  // flip-flop output through the whole access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= next_prdata;
    end
  end

  // ****************************************************************
  // time bases
  // ****************************************************************
  // bit 7 picks programmable divider or the fixed 50khz base
  fpm_tick #(.WIDTH(32)) u_ref (
    .pclk    (pclk),
    .presetn (presetn),
    .div     (reference_select_byte_bit ? ref_div : `FPM_BASE_DIV),
    .tick    (ref_tick)
  );

  // pulse-low always runs on the fixed base, whatever bit 7 says
  fpm_tick #(.WIDTH(32)) u_base (
    .pclk    (pclk),
    .presetn (presetn),
    .div     (`FPM_BASE_DIV),
    .tick    (base_tick)
  );

  // ****************************************************************
  // edge detection
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // the measured input idles high: a low here would fake a rising edge
      clk_d   <= 1'b1;
      start_d <= 1'b0;
    end else begin
      clk_d   <= clk_in;
      start_d <= start_in;
    end
  end

  // ****************************************************************
  // frequency / period measurement
  // ****************************************************************
  always @* begin
    next_low  = low_pair;
    next_high = high_pair;
    case (mode)
      `FPM_MODE_PERIOD: begin
        if (clk_rise)
          next_low = low_pair + 32'h0000_0001;
        if (ref_tick)
          next_high = high_pair + 32'h0000_0001;
      end
      `FPM_MODE_FREQ, `FPM_MODE_FREQ_GATE: begin
        if (ref_tick)
          next_low = low_pair + 32'h0000_0001;
        if (clk_rise)
          next_high = high_pair + 32'h0000_0001;
      end
      default: begin
        next_low  = low_pair;
        next_high = high_pair;
      end
    endcase
  end

  // ****************************************************************
  // measurement state machine
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_IDLE;
      low_pair  <= 32'h0000_0000;
      high_pair <= 32'h0000_0000;
      done_flag <= 1'b0;
    end else if (!is_meas) begin
      // leaving the measurement modes parks the machine, pairs are kept
      state <= ST_IDLE;
    end else if (counter_clear_input) begin
      state     <= ST_IDLE;
      low_pair  <= 32'h0000_0000;
      high_pair <= 32'h0000_0000;
      done_flag <= 1'b0;
    end else begin
      case (state)
        ST_IDLE, ST_DONE: begin
          if (start_rise) begin
            state     <= ST_ARM;
            low_pair  <= 32'h0000_0000;
            high_pair <= 32'h0000_0000;
            done_flag <= 1'b0;
          end
        end
        ST_ARM: begin
          if (stop_in) begin
            state     <= ST_DONE;
            done_flag <= 1'b1;
          end else if (clk_rise) begin
            // the first clock edge after start is already counted
            state <= ST_RUN;
            if (is_period)
              low_pair <= 32'h0000_0001;
            else
              high_pair <= 32'h0000_0001;
          end
        end
        ST_RUN: begin
          low_pair  <= next_low;
          high_pair <= next_high;
          // match tested on the next value so the final count is kept
          if (stop_in || next_low >= compare) begin
            state     <= ST_DONE;
            done_flag <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // pulse-low measurement
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_run         <= 1'b0;
      pulse_count       <= 32'h0000_0000;
      result_input_area <= 32'h0000_0000;
      result_new        <= 1'b0;
    end else if (!is_pulse) begin
      pulse_run <= 1'b0;
    end else if (counter_clear_input) begin
      pulse_run   <= 1'b0;
      pulse_count <= 32'h0000_0000;
    end else begin
      if (clk_fall) begin
        pulse_run   <= 1'b1;
        pulse_count <= 32'h0000_0000;
      end else if (clk_rise && pulse_run) begin
        pulse_run         <= 1'b0;
        result_input_area <= pulse_count;
        result_new        <= 1'b1;
      end else if (pulse_run && base_tick) begin
        // a down count wraps below zero and reads back as two's complement
        if (dir_in)
          pulse_count <= pulse_count - 32'h0000_0001;
        else
          pulse_count <= pulse_count + 32'h0000_0001;
      end
      // a result landing with the read keeps its flag: the set wins
      if (psel && penable && !pwrite &&
          addr_hit(paddr, `FPM_RESULT_OFS) && !(clk_rise && pulse_run))
        result_new <= 1'b0;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out0 <= 1'b0;
      out1 <= 1'b0;
    end else begin
      // outputs follow the state one cycle late
      case (mode)
        `FPM_MODE_FREQ_GATE: begin
          out0 <= (state == ST_RUN);
          out1 <= ~(state == ST_RUN);
        end
        `FPM_MODE_FREQ, `FPM_MODE_PERIOD: begin
          out0 <= (state == ST_RUN);
          out1 <= (state == ST_DONE);
        end
        default: begin
          out0 <= out0;
          out1 <= out1;
        end
      endcase
    end
  end

endmodule // fpm_channel

`default_nettype wire

/* testbench/fpm_channel_props.sv */
// checker: port-level properties of the measurement channel
// assumes bind onto fpm_channel; mode is tracked from apb writes
`timescale 1ns/1ns
`default_nettype none
module fpm_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        clk_in,
  input wire logic        counter_clear_input,
  input wire logic        start_in,
  input wire logic        stop_in,
  input wire logic        dir_in,
  input wire logic        out0,
  input wire logic        out1
);
  logic [4:0] mode;
  logic       refsel;
  wire        rd = psel && penable && !pwrite;
  wire        meas = (mode == 5'h10) || (mode == 5'h11) || (mode == 5'h12);
  always @(posedge pclk or negedge presetn)
    if (!presetn) begin
      mode <= 5'h00;
      refsel <= 1'b0;
    end else if (psel && penable && pwrite && paddr == 12'h000) begin
      mode <= pwdata[4:0];
      refsel <= pwdata[7];
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_inv; mode == 5'h12 && $past(mode) == 5'h12
    && $past(mode, 2) == 5'h12 |-> out1 != out0; endproperty
  a_inv: assert property (p_inv) else $error("gate inverse");
  property p_hold; mode == 5'h06 && $past(mode) == 5'h06
    |-> $stable(out0) && $stable(out1); endproperty
  a_hold: assert property (p_hold) else $error("outputs moved");
  property p_cmp; rd && paddr == 12'h004 |-> prdata != 32'h0; endproperty
  a_cmp: assert property (p_cmp) else $error("compare zero");
  property p_frq; mode == 5'h10 && $past(mode) == 5'h10
    |-> !(out0 && out1); endproperty
  a_frq: assert property (p_frq) else $error("active and ended");
  property p_on; mode == 5'h12 && $rose(out0)
    |-> $past(clk_in) || $past(clk_in, 2) || $past(clk_in, 3); endproperty
  a_on: assert property (p_on) else $error("gate without clock");
  property p_stop; (mode == 5'h12 && stop_in)[*3] |-> !out0; endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  property p_clr; rd && (paddr == 12'h00c || paddr == 12'h010)
    && $past(counter_clear_input, 2) && $past(meas, 2)
    |-> prdata == 32'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
  property p_ref; rd && paddr == 12'h000 |-> prdata[7] == refsel; endproperty
  a_ref: assert property (p_ref) else $error("ref select lost");
endmodule // fpm_chk
bind fpm_channel fpm_chk u_fpm_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .clk_in(clk_in), .counter_clear_input(counter_clear_input),
  .start_in(start_in), .stop_in(stop_in), .dir_in(dir_in),
  .out0(out0), .out1(out1));
`default_nettype wire

/* testbench/fpm_field.sv */
// field source model: square wave on the measured input
// assumes hi/lo phase lengths in pclk cycles; idles high when disabled
`timescale 1ns/1ns
`default_nettype none
module fpm_field (
  input wire logic        pclk,
  input wire logic        en,
  input wire logic [15:0] hi,
  input wire logic [15:0] lo,
  output logic            clk_in
);
  logic [15:0] cnt;
  initial clk_in = 1'b1;
  initial cnt = 16'h0;
  always @(posedge pclk)
    if (!en) begin
      clk_in <= 1'b1;
      cnt <= 16'h0;
    end else if (cnt >= (clk_in ? hi : lo) - 16'h1) begin
      clk_in <= !clk_in;
      cnt <= 16'h0;
    end else
      cnt <= cnt + 16'h1;
endmodule // fpm_field
`default_nettype wire

/* testbench/freq_period_pulse_measure_tb_top.sv */
// testbench: apb master, field stimulus, expected counts from integers
// assumes fpm_channel with zero-wait apb and the fpm_field source
`timescale 1ns/1ns
`default_nettype none
module freq_period_pulse_measure_tb_top;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        clk_in, clear, start_in, stop_in, dir_in, out0, out1, en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, lowc, highc;
  logic [31:0] seed = 32'h6;
  logic [15:0] hi, lo;
  logic [4:0]  m;
  logic [1:0]  ob;
  int          n_fail = 0, n_tests = 0, i, k, n, p, len;
  always #4 pclk = ~pclk;
  fpm_channel u_fpm_channel (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .clk_in(clk_in),
    .counter_clear_input(clear), .start_in(start_in), .stop_in(stop_in),
    .dir_in(dir_in), .out0(out0), .out1(out1));
  fpm_field u_fpm_field (.pclk(pclk), .en(en), .hi(hi), .lo(lo),
    .clk_in(clk_in));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 50);
    q = prdata;
    err = pslverr;
    if (t >= 50) n_fail++;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] lw, input logic [31:0] hg);
    n_tests++;
    if ((g >= lw && g <= hg) !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h..%h", $time, g, lw, hg);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    end_of_test;
  end
  initial begin
    {presetn, psel, penable, pwrite, clear, start_in, stop_in, dir_in, en} = 0;
    paddr = 12'h0; pwdata = 32'h0; hi = 16'h2; lo = 16'h2;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h000, 0); chk(q, 0, 0);
    apb(0, 12'h018, 0); chk(q, 32'h7d, 32'h7d);
    apb(0, 12'h040, 0); chk(err, 1, 1);
    apb(1, 12'h004, 0); apb(0, 12'h004, 0); chk(q, 1, 1);
    apb(1, 12'h004, '1); apb(0, 12'h004, 0); chk(q, '1, '1);
    apb(1, 12'h018, 1);
    for (i = 0; i < 4; i++) begin
      m = (i == 1) ? 5'h11 : (i == 0) ? 5'h10 : 5'h12;
      n = 40 + xs() % 20;
      p = 2 + xs() % 3;
      hi <= 16'(p);
      lo <= 16'(p);
      apb(1, 12'h000, {24'h0, 3'b100, m});
      apb(1, 12'h004, n);
      p = 2 * p;
      clear <= 1'b1;
      @(posedge pclk);
      apb(0, 12'h00c, 0); chk(q, 0, 0);
      apb(0, 12'h010, 0); chk(q, 0, 0);
      clear <= 1'b0; start_in <= 1'b1;
      @(posedge pclk);
      start_in <= 1'b0; en <= 1'b1;
      if (i == 3) begin
        repeat (30) @(posedge pclk);
        stop_in <= 1'b1;
        repeat (5) @(posedge pclk);
      end
      k = 0;
      do begin apb(0, 12'h008, 0); k++; end while (q[2] !== 1'b1 && k < 400);
      chk(q[2], 1, 1);
      stop_in <= 1'b0; en <= 1'b0;
      apb(0, 12'h00c, 0); lowc = q;
      apb(0, 12'h010, 0); highc = q;
      if (i == 1) begin
        chk(lowc, n, n);
        chk(highc, n * p - p, n * p + p);
        chk(highc / lowc, p - 1, p);
      end else if (i == 3) chk(lowc, 1, n - 1);
      else begin
        chk(lowc, n, n);
        chk(highc, n / p - 1, n / p + 1);
        chk(highc * p, lowc - p, lowc + p);
      end
      if (i != 1) chk({out0, out1}, 1, 1);
      apb(0, 12'h000, 0); chk(q[7], 1, 1);
    end
    apb(1, 12'h000, 32'h06);
    for (i = 0; i < 2; i++) begin
      k = 2 + xs() % 3;
      len = 2500 * k + 1250;
      dir_in <= i[0]; clear <= 1'b1;
      @(posedge pclk);
      clear <= 1'b0; ob = {out0, out1};
      hi <= 16'd8; lo <= len[15:0]; en <= 1'b1;
      repeat (len + 10) @(posedge pclk);
      en <= 1'b0;
      repeat (3) @(posedge pclk);
      apb(0, 12'h014, 0);
      if (i == 0) chk(q, k - 1, k + 1);
      else chk(-q, k - 1, k + 1);
      chk({out0, out1}, ob, ob);
    end
    end_of_test;
  end
endmodule // freq_period_pulse_measure_tb_top
`default_nettype wire
